/* sbrd_pkg.sv */
/*
  Package for the serial baud rate divider: register indices, field
  positions, reset values and timing constants.
  Assumes an 8-bit register port inside a serial block of eight registers.
*/
package sbrd_pkg;
  // ************************************************************
  // Register map (byte index on the plain register port)
  // ************************************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_DIV_HIGH = 3'h0;
  localparam logic [2:0] REG_DIV_LOW = 3'h1;
  localparam logic [2:0] REG_CTRL_TWO = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_BRK_IE = 7;
  localparam int BIT_EDGE_IE = 6;
  localparam int BIT_TX_ON = 3;
  localparam int BIT_RX_ON = 2;
  localparam int DIV_HI_W = 5;
  localparam int DIV_W = 13;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h04;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OVS_LAST = 4'hF;
  typedef enum logic [1:0] {SBRD_IDLE = 2'b00, SBRD_RUN = 2'b01} sbrd_state_e;
endpackage

/* sbrd_baud_divider.sv */
/*
  Baud rate divider of the serial block with its divisor register pair,
  the interrupt enables in the high divisor register and the second
  control register's receive and transmit enables.
  Assumes break and edge flags arrive from logic on the same clock.
*/
`timescale 1ns/1ns
module sbrd_baud_divider #(
  parameter int DIV_WIDTH = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [sbrd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic break_detect_flag,
  input wire logic rx_edge_flag,
  output logic breakIrq,
  output logic edgeIrq,
  output logic rx_on,
  output logic tx_on,
  output logic sampleTick,
  output logic bitTick,
  output logic rateActive
);
  import sbrd_pkg::*;

  initial begin
    if (DIV_WIDTH != DIV_W) $error("DIV_WIDTH must be 13");
    if (DIV_HI_W + 8 != DIV_W) $error("Divisor halves must add up to DIV_W");
    if (ADDR_W < 3) $error("Register index must reach eight registers");
    if (OVERSAMPLE != 16 || OVS_LAST != 4'(OVERSAMPLE - 1)) $error("Sample counter sized for sixteen");
    if (RST_DIV_LOW == 8'h00) $error("Low divisor byte must reset nonzero");
  end

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Strobe aimed at one register index
  function automatic logic hitReg(input logic strobe, input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx);
    return strobe && (addr == idx);
  endfunction

  // Bit 5 has no function and is never stored
  function automatic logic [7:0] maskHigh(input logic [7:0] value);
    return {value[7:6], 1'b0, value[DIV_HI_W-1:0]};
  endfunction

  // Either direction enabled
  function automatic logic anyEnable(input logic [7:0] ctrl);
    return ctrl[BIT_RX_ON] || ctrl[BIT_TX_ON];
  endfunction

  // Last clock of a sample period; >= lets a shrinking divisor end at once
  function automatic logic periodDone(input logic [DIV_W-1:0] count, input logic [DIV_W-1:0] divisor);
    return count >= (divisor - DIV_W'(1));
  endfunction

  // Status byte: bit 1 start latch, bit 0 generator running
  function automatic logic [7:0] statusByte(input logic stFlag, input logic runFlag);
    return {6'h00, stFlag, runFlag};
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] highBuf_reg, highBuf_next;
  logic [4:0] highWork_reg, highWork_next;
  logic [7:0] lowDiv_reg, lowDiv_next;
  logic [7:0] ctrlTwo_reg, ctrlTwo_next;
  logic started_reg, started_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [DIV_W-1:0] baud_divisor_value;
  logic wrHigh;
  logic wrLow;
  logic wrCtrl;

  assign wrHigh = hitReg(regWrite, regAddr, REG_DIV_HIGH);
  assign wrLow = hitReg(regWrite, regAddr, REG_DIV_LOW);
  assign wrCtrl = hitReg(regWrite, regAddr, REG_CTRL_TWO);

  // ************************************************************
  // Divisor pair
  // ************************************************************
  always_comb begin
    highBuf_next = highBuf_reg;
    highWork_next = highWork_reg;
    lowDiv_next = lowDiv_reg;
    if (wrHigh) begin
      highBuf_next = maskHigh(regWdata);
    end
    if (wrLow) begin
      lowDiv_next = regWdata;
      // Upper bits move only now, so a half-written divisor never runs
      highWork_next = highBuf_reg[DIV_HI_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highBuf_reg <= RST_DIV_HIGH;
      highWork_reg <= RST_DIV_HIGH[DIV_HI_W-1:0];
      lowDiv_reg <= RST_DIV_LOW;
    end else begin
      highBuf_reg <= highBuf_next;
      highWork_reg <= highWork_next;
      lowDiv_reg <= lowDiv_next;
    end
  end

  assign baud_divisor_value = {highWork_reg, lowDiv_reg};

  // ************************************************************
  // Second control register
  // ************************************************************
  always_comb begin
    ctrlTwo_next = ctrlTwo_reg;
    if (wrCtrl) begin
      ctrlTwo_next = regWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlTwo_reg <= RST_CTRL_TWO;
    end else begin
      ctrlTwo_reg <= ctrlTwo_next;
    end
  end

  assign rx_on = ctrlTwo_reg[BIT_RX_ON];
  assign tx_on = ctrlTwo_reg[BIT_TX_ON];

  // ************************************************************
  // Start latch
  // ************************************************************
  // Sticky until reset: the nonzero reset divisor must not run on its own
  always_comb begin
    started_next = started_reg;
    if (anyEnable(ctrlTwo_reg)) begin
      started_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= started_next;
    end
  end

  // ************************************************************
  // Interrupt gating
  // ************************************************************
  // Levels, not pulses: the flag owner clears them
  logic [1:0] irqEn;
  logic [1:0] irqFlag;
  logic [1:0] irqOut;
  assign irqEn = {highBuf_reg[BIT_BRK_IE], highBuf_reg[BIT_EDGE_IE]};
  assign irqFlag = {break_detect_flag, rx_edge_flag};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gIrq
      assign irqOut[g] = irqEn[g] & irqFlag[g];
    end
  endgenerate
  assign breakIrq = irqOut[1];
  assign edgeIrq = irqOut[0];

  // ************************************************************
  // Read port
  // ************************************************************
  // Other serial registers live outside; their indices read zero here
  always_comb begin
    rdata_next = 8'h00;
    if (regRead) begin
      case (regAddr)
        REG_DIV_HIGH: rdata_next = highBuf_reg;
        REG_DIV_LOW: rdata_next = lowDiv_reg;
        REG_CTRL_TWO: rdata_next = ctrlTwo_reg;
        REG_STATUS: rdata_next = statusByte(started_reg, rateActive);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign regRdata = rdata_reg;

  // ************************************************************
  // Rate generator
  // ************************************************************
  sbrd_state_e state_reg, state_next;
  logic [DIV_W-1:0] divCnt_reg, divCnt_next;
  logic [3:0] ovsCnt_reg, ovsCnt_next;
  logic sTick_reg, sTick_next;
  logic bTick_reg, bTick_next;
  logic enable;
  logic running;
  logic wrapNow;

  // Zero divisor parks the counters so nothing toggles
  assign enable = started_reg && (baud_divisor_value != '0);
  assign running = (state_reg == SBRD_RUN);
  assign wrapNow = running && enable && periodDone(divCnt_reg, baud_divisor_value);

  // ************************************************************
  // Run state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SBRD_IDLE: begin
        if (enable) begin
          state_next = SBRD_RUN;
        end
      end
      SBRD_RUN: begin
        if (!enable) begin
          state_next = SBRD_IDLE;
        end
      end
      default: begin
        state_next = SBRD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SBRD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Divide and oversample counters
  // ************************************************************
  always_comb begin
    divCnt_next = divCnt_reg;
    ovsCnt_next = ovsCnt_reg;
    sTick_next = 1'b0;
    bTick_next = 1'b0;
    if (!running) begin
      divCnt_next = '0;
      ovsCnt_next = 4'h0;
    end else if (wrapNow) begin
      divCnt_next = '0;
      sTick_next = 1'b1;
      ovsCnt_next = ovsCnt_reg + 4'h1;
      bTick_next = (ovsCnt_reg == OVS_LAST);
    end else if (enable) begin
      divCnt_next = divCnt_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= '0;
      ovsCnt_reg <= 4'h0;
      sTick_reg <= 1'b0;
      bTick_reg <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_next;
      ovsCnt_reg <= ovsCnt_next;
      sTick_reg <= sTick_next;
      bTick_reg <= bTick_next;
    end
  end

  assign sampleTick = sTick_reg;
  assign bitTick = bTick_reg;
  assign rateActive = running;
endmodule

/* sbrd_baud_chk.sv */
/* Port assertions for the baud divider. Assumes a bind to sbrd_baud_divider. */
`timescale 1ns/1ns
module sbrd_baud_chk #(parameter int DIV_WIDTH = 13) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic break_detect_flag,
  input wire logic rx_edge_flag,
  input wire logic breakIrq,
  input wire logic edgeIrq,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic sampleTick,
  input wire logic bitTick,
  input wire logic rateActive
);
  logic [7:0] hiReg;
  logic [DIV_WIDTH-1:0] divReg;
  logic [15:0] gapReg;
  logic okReg;
  logic onReg;
  // Divisor writes restart the gap check, tick phase is then unknown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiReg <= 8'h00;
      divReg <= DIV_WIDTH'(8'h04);
      gapReg <= 16'h0;
      okReg <= 1'b0;
      onReg <= 1'b0;
    end else begin
      if (regWrite && regAddr == 3'h0) hiReg <= regWdata;
      if (regWrite && regAddr == 3'h1) divReg <= DIV_WIDTH'({hiReg[4:0], regWdata});
      okReg <= (regWrite && regAddr <= 3'h1) ? 1'b0 : (okReg || sampleTick);
      gapReg <= sampleTick ? 16'h1 : gapReg + 16'h1;
      onReg <= onReg || rx_on || tx_on;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  brk_irq_gate_a: assert property (breakIrq == (break_detect_flag && hiReg[7])) else $error("brk irq");
  edge_irq_gate_a: assert property (edgeIrq == (rx_edge_flag && hiReg[6])) else $error("edge irq");
  high_readback_a: assert property (regRead && regAddr == 3'h0 |=> regRdata == {hiReg[7:6], 1'b0, hiReg[4:0]})
    else $error("high read");
  tick_spacing_a: assert property (sampleTick && okReg |-> gapReg == 16'(divReg)) else $error("tick gap");
  zero_stops_a: assert property ((divReg == 0) [*3] |-> !sampleTick && !bitTick) else $error("zero div");
  idle_until_on_a: assert property (sampleTick || rateActive |-> onReg) else $error("early run");
  enable_load_a: assert property (regWrite && regAddr == 3'h3 |=> rx_on == $past(regWdata[2]) &&
    tx_on == $past(regWdata[3])) else $error("enables");
  unmapped_zero_a: assert property (regRead && regAddr == 3'h7 |=> regRdata == 8'h00) else $error("unmapped");
endmodule

/* sbrd_remote_model.sv */
/* Far-side model raising break and edge flags. Assumes the bench clock. */
`timescale 1ns/1ns
module sbrd_remote_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sendBreak,
  input wire logic edgeIn,
  output logic breakFlag,
  output logic edgeFlag
);
  // Registered, a detector reports one clock late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breakFlag <= 1'b0;
      edgeFlag <= 1'b0;
    end else begin
      breakFlag <= sendBreak;
      edgeFlag <= edgeIn;
    end
  end
endmodule

/* test_sbrd_baud_divider.sv */
/* Bench for the baud divider. Assumes package, checker and model compiled first. */
`timescale 1ns/1ns
module test_sbrd_baud_divider;
  import sbrd_pkg::*;
  logic clk, rst_n, regWrite, regRead, sendBreak, edgeIn, brkF, edgeF, brkIrq, edgeIrq, rxOn, txOn, sTick, bTick, act;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic [12:0] d;
  integer seed = 32'h3633, n_fail = 0, checks_done = 0, cyc = 0;
  sbrd_baud_divider sbrd_baud_divider_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .break_detect_flag(brkF), .rx_edge_flag(edgeF),
    .breakIrq(brkIrq), .edgeIrq(edgeIrq), .rx_on(rxOn), .tx_on(txOn), .sampleTick(sTick), .bitTick(bTick),
    .rateActive(act));
  sbrd_remote_model sbrd_remote_model_inst (.clk(clk), .rst_n(rst_n), .sendBreak(sendBreak), .edgeIn(edgeIn),
    .breakFlag(brkF), .edgeFlag(edgeF));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling covers the long 8191 divisor gap seven times over
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  task cmp(input [15:0] got, input [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    cmp(regRdata, e);
    @(negedge clk);
    cmp(regRdata, 8'h00);
  endtask
  task meas(input bit b, input [15:0] e);
    int n;
    n = 0;
    do @(negedge clk); while ((b ? bTick : sTick) !== 1'b1 && ++n < 9000);
    n = 0;
    do begin @(negedge clk); n++; end while ((b ? bTick : sTick) !== 1'b1 && n < 9000);
    cmp(16'(n), e);
  endtask
  function automatic [1:0] irqExp(input [1:0] en, input b, input e);
    return en & {b, e};
  endfunction
  initial begin
    {rst_n, regWrite, regRead, sendBreak, edgeIn, regAddr, regWdata} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_DIV_HIGH, RST_DIV_HIGH);
    rd(REG_DIV_LOW, RST_DIV_LOW);
    rd(3'h7, 8'h00);
    repeat (40) begin
      @(negedge clk);
      cmp({sTick, act}, 16'h0);
    end
    wr(REG_DIV_HIGH, 8'hFF);
    rd(REG_DIV_HIGH, 8'hDF);
    wr(REG_CTRL_TWO, 8'h04);
    rd(REG_CTRL_TWO, 8'h04);
    cmp({rxOn, txOn}, 16'h2);
    meas(1'b0, 16'h4);
    rd(REG_STATUS, 8'h03);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 13'h1 : (i == 4) ? 13'h1FFF : 13'(2 + ($random(seed) & 7));
      wr(REG_DIV_HIGH, {3'h0, d[12:8]});
      wr(REG_DIV_LOW, d[7:0]);
      meas(1'b0, 16'(d));
      if (i < 4) meas(1'b1, 16'(d) * 16'(OVERSAMPLE));
    end
    wr(REG_DIV_HIGH, 8'h00);
    wr(REG_DIV_LOW, 8'h00);
    repeat (2) @(negedge clk);
    repeat (300) begin
      @(negedge clk);
      cmp({sTick, bTick}, 16'h0);
    end
    for (int k = 0; k < 8; k++) begin
      d = 13'($random(seed));
      wr(REG_DIV_HIGH, {d[1:0], 6'h0});
      sendBreak <= d[2];
      edgeIn <= d[3];
      repeat (2) @(negedge clk);
      cmp({brkIrq, edgeIrq}, irqExp(d[1:0], d[2], d[3]));
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp({sTick, act, rxOn, txOn, brkIrq, edgeIrq}, 16'h0);
    rd(REG_STATUS, 8'h00);
    rd(REG_DIV_LOW, RST_DIV_LOW);
    finish_test();
  end
endmodule
bind sbrd_baud_divider sbrd_baud_chk #(.DIV_WIDTH(DIV_WIDTH)) sbrd_baud_chk_inst (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .break_detect_flag(break_detect_flag), .rx_edge_flag(rx_edge_flag), .breakIrq(breakIrq), .edgeIrq(edgeIrq),
  .rx_on(rx_on), .tx_on(tx_on), .sampleTick(sampleTick), .bitTick(bitTick), .rateActive(rateActive));
